/* bench/sahp_props.sv */
`timescale 1ns/1ps
module sahp_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic convert_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic adc_reset,
    input wire logic power_down_in,
    input wire logic interface_sel,
    input wire logic busy,
    input wire logic [15:0] d_dev_oe
);
    logic [7:0] len_q;
    // counts the cycles of one busy period
    always_ff @(posedge clock) len_q <= busy ? len_q + 8'h01 : 8'h00;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // an accepted start request from an idle converter
    sequence start_s;
        $fell(convert_start_n) && !busy && !power_down_in && !adc_reset;
    endsequence
    start_busy_a: assert property (start_s |-> ##[1:12] busy)
        else $error("busy missing after start");
    busy_hold_a: assert property ($rose(busy) |=> busy[*8])
        else $error("busy dropped early");
    busy_max_a: assert property (busy |-> len_q < 8'h64)
        else $error("busy too long");
    pd_block_a: assert property ($fell(convert_start_n) && !busy
        && power_down_in && $past(power_down_in, 4) |=> !busy[*8])
        else $error("conversion during power down");
    reset_abort_a: assert property (adc_reset[*4] |->
        !busy && !(|d_dev_oe))
        else $error("reset did not abort");
    // serial clock, frame sync and error lines are not part of the read path
    oe_gate_a: assert property ((cs_n || rd_n)[*4] |->
        (d_dev_oe & 16'hf1ff) == 16'h0000)
        else $error("lines driven without select");
    ser_float_a: assert property (interface_sel[*4] |->
        d_dev_oe[1:0] == 2'h0 && d_dev_oe[15:12] == 4'h0)
        else $error("serial mode drives floating lines");
    ser_input_a: assert property (interface_sel[*4] |->
        d_dev_oe[7:2] == 6'h00)
        else $error("serial mode drives select lines");
endmodule

/* bench/tb_sar_adc_host_port.sv */
`timescale 1ns/1ps
module tb_sar_adc_host_port;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] sample_value = 16'ha5c3;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, low_power_active;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    sahp_if bus();
    sahp_host #(.FAST_GAP(200)) sahp_host_i (.clock(clock), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(bus.host));
    sahp_device sahp_device_i (.clock(clock), .sys_rst(sys_rst),
        .pins(bus.device), .sample_value(sample_value),
        .low_power_active(low_power_active), .last_result());
    sahp_props sahp_props_i (.clock(clock), .sys_rst(sys_rst),
        .convert_start_n(bus.convert_start_n), .cs_n(bus.cs_n),
        .rd_n(bus.rd_n), .adc_reset(bus.adc_reset),
        .power_down_in(bus.power_down_in), .interface_sel(bus.interface_sel),
        .busy(bus.busy), .d_dev_oe(bus.d_dev_oe));
    // clock, and a ceiling on the run length
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task report_and_stop;
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // one apb transfer; holds the request until pready
    task automatic apb(input logic w, input logic [11:0] a, [31:0] wd);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // polls one status bit until it reads v; a miss counts as a mismatch
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (rd[b] !== v && n < 300);
        chk("status wait", {31'h0, v}, {31'h0, rd[b]});
    endtask
    task automatic check_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h8, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
    endtask
    // parallel, byte order, coding, master, divider, slave, speed, invert
    task automatic conv_modes;
        logic [12:0] cf [11] = '{13'h8, 13'h0, 13'hc, 13'h18, 13'h618,
            13'h38, 13'h10, 13'h9, 13'ha, 13'h98, 13'hb8};
        logic [31:0] want;
        foreach (cf[i]) begin
            sample_value <= sample_value ^ 16'h3c5a;
            apb(1'b1, 12'h000, {19'h0, cf[i]});
            apb(1'b1, 12'h008, 32'h6);
            apb(1'b1, 12'h004, 32'h1);
            wait_st(0, 1'b1);
            wait_st(0, 1'b0);
            apb(1'b1, 12'h004, 32'h2);
            wait_st(1, 1'b1);
            apb(1'b0, 12'h00c, 32'h0);
            want = {16'h0, sample_value ^ {~cf[i][3], 15'h0}};
            chk("result", want, rd);
            want = {31'h0, cf[i][1] & ~cf[i][0]};
            chk("lowpwr", want, {31'h0, low_power_active});
        end
    endtask
    task automatic pd_abort;
        apb(1'b1, 12'h000, 32'h808);
        apb(1'b1, 12'h004, 32'h1);
        repeat (30) @(posedge clock);
        apb(1'b0, 12'h008, 32'h0);
        chk("pd busy", 32'h0, {31'h0, rd[0]});
        apb(1'b1, 12'h000, 32'h8);
        apb(1'b1, 12'h004, 32'h1);
        wait_st(0, 1'b1);
        repeat (20) @(posedge clock);
        apb(1'b1, 12'h000, 32'h1008);
        repeat (8) @(posedge clock);
        apb(1'b0, 12'h008, 32'h0);
        chk("abort busy", 32'h0, {31'h0, rd[0]});
        apb(1'b1, 12'h000, 32'h8);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        check_reset();
        conv_modes();
        pd_abort();
        report_and_stop();
    end
endmodule

/* rtl/sahp_defines.svh */
`ifndef SAHP_DEFINES_SVH
`define SAHP_DEFINES_SVH

// conversion and acquisition lengths in clock cycles (50 MHz clock)
`define SAHP_CONV_CYC_FAST 50
`define SAHP_CONV_CYC_NORMAL 63
`define SAHP_CONV_CYC_LOWPWR 75
`define SAHP_ACQ_CYC 12
// host side timing in clock cycles
`define SAHP_CNV_PULSE_CYC 4
`define SAHP_PAR_WAIT_CYC 8
`define SAHP_SLAVE_HALF_CYC 10
`define SAHP_FAST_GAP_CYC 4000
// result word width
`define SAHP_WORD_W 16
// host register offsets
`define SAHP_REG_CTRL 12'h000
`define SAHP_REG_CMD 12'h004
`define SAHP_REG_STATUS 12'h008
`define SAHP_REG_RESULT 12'h00c
// control register fields
`define SAHP_CTRL_FAST 0
`define SAHP_CTRL_LOWPWR 1
`define SAHP_CTRL_BYTE_ORDER 2
`define SAHP_CTRL_CODING 3
`define SAHP_CTRL_IFACE 4
`define SAHP_CTRL_CLK_SRC 5
`define SAHP_CTRL_SYNC_POL 6
`define SAHP_CTRL_CLK_INV 7
`define SAHP_CTRL_READ_MODE 8
`define SAHP_CTRL_DIV_LO 9
`define SAHP_CTRL_DIV_HI 10
`define SAHP_CTRL_PWR_DOWN 11
`define SAHP_CTRL_ADC_RST 12
`define SAHP_CTRL_W 13
`define SAHP_CTRL_RESET 13'h0008
// command register fields
`define SAHP_CMD_CONVERT 0
`define SAHP_CMD_READ 1
// status register fields
`define SAHP_STAT_BUSY 0
`define SAHP_STAT_VALID 1
`define SAHP_STAT_RDERR 2
`define SAHP_STAT_ACTIVE 3

`endif

/* rtl/sahp_device.sv */
// Summary of operation
// - byte order select swaps parallel result bytes
// - coding select low inverts result MSB
// - fast mode alone gives shortest conversion time
// - low power mode alone selects reduced power
// - interface select picks parallel or serial port
// - serial mode floats data lines 0-1, 12-15
// - divider slows master clock in read-after-convert
// - clock source picks master or slave clock
// - sync polarity input sets frame sync level
// - clock invert applies in master and slave
// - slave mode chains input data after 16 clocks
// - read mode picks during or after conversion
// - serial result leaves MSB first, chosen coding
// - slave data changes on active clock edge
// - serial clock pin direction follows source
// - frame sync held while serial data valid in master mode
// - unfinished slave read at conversion pulses error
// - busy high from start until result latched
// - outputs except lines 9-11 enabled only with chip select, read
// - reset input aborts conversion in progress
// - power down finishes current, inhibits next
// - falling convert start begins conversion
`timescale 1ns/1ps
`include "sahp_defines.svh"
module sahp_device import sahp_pkg::*; #(
    parameter int CONV_FAST = `SAHP_CONV_CYC_FAST,
    parameter int CONV_NORMAL = `SAHP_CONV_CYC_NORMAL,
    parameter int CONV_LOWPWR = `SAHP_CONV_CYC_LOWPWR,
    parameter int ACQ_LEN = `SAHP_ACQ_CYC
) (
    input logic clock,
    input logic sys_rst,
    sahp_if.device pins,
    input logic [15:0] sample_value,
    output logic low_power_active,
    output logic [15:0] last_result
);
    logic [25:0] s;
    logic cnv_n, cs_n, rd_n, arst, pd, bsw, obc, ser, fast, lpw;
    logic [1:0] div;
    logic ext, spol, sinv, rdc, sclk_in;
    logic out_en, fast_mode_on, low_pwr_on, cnv_fall, conv_start, conv_done;
    logic [15:0] coded;
    logic [15:0] conv_len;
    sahp_dev_state_t state_q;
    logic [15:0] cnt_q;
    logic cnv_prev_q, en_prev_q, clk_prev_q, busy_q;
    logic [15:0] hold_q, result_q, sh_q;
    logic pend_q, sact_q, ph_q, rderr_q;
    logic [3:0] hc_q, half_len;
    logic [4:0] bit_q;
    logic eff_clk, eff_rise, mstart, sstart;
    logic [15:0] d_o, d_e, d_out_q, d_oe_q;

    // every pin from the host passes two flip-flops
    sahp_sync2 #(.W(26), .RST_VAL(26'h3800000)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({pins.convert_start_n, pins.cs_n, pins.rd_n,
                   pins.adc_reset, pins.power_down_in, pins.byte_order_sel,
                   pins.output_coding_sel, pins.interface_sel,
                   pins.fast_mode, pins.low_power_mode, pins.d_wire}),
        .sync_out(s)
    );

    // decode of the synchronised pins
    assign {cnv_n, cs_n, rd_n, arst, pd, bsw, obc, ser, fast, lpw} = s[25:16];
    assign div = s[3:2];
    assign ext = s[4];
    assign spol = s[5];
    assign sinv = s[6];
    assign rdc = s[7];
    assign sclk_in = s[9];
    assign out_en = !cs_n && !rd_n;
    assign fast_mode_on = fast && !lpw;
    assign low_pwr_on = lpw && !fast;
    assign cnv_fall = cnv_prev_q && !cnv_n;
    assign conv_done = (state_q == DEV_CONV) && (cnt_q == 16'h0001);
    assign conv_start = !pd && (((state_q == DEV_IDLE) && cnv_fall) ||
                        ((state_q == DEV_ACQ) && (cnt_q == 16'h0001) &&
                         low_pwr_on && !cnv_n));
    // coding select: high straight binary, low inverts the msb
    assign coded = {result_q[15] ^ ~obc, result_q[14:0]};
    assign conv_len = fast_mode_on ? 16'(CONV_FAST) :
                      (low_pwr_on ? 16'(CONV_LOWPWR) : 16'(CONV_NORMAL));

    // edge history of convert start and output enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnv_prev_q <= 1'b1;
            en_prev_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            cnv_prev_q <= cnv_n;
            en_prev_q <= out_en;
            clk_prev_q <= eff_clk;
        end
    end

    // conversion sequencer
    always_ff @(posedge clock) begin
        if (sys_rst || arst) begin
            state_q <= DEV_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                DEV_IDLE: begin
                    if (conv_start) begin
                        state_q <= DEV_CONV;
                        cnt_q <= conv_len;
                    end
                end
                DEV_CONV: begin
                    if (conv_done) begin
                        state_q <= DEV_ACQ;
                        cnt_q <= 16'(ACQ_LEN);
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                DEV_ACQ: begin
                    if (cnt_q == 16'h0001) begin
                        // low power mode restarts if start is still low
                        state_q <= conv_start ? DEV_CONV : DEV_IDLE;
                        cnt_q <= conv_start ? conv_len : 16'h0000;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= DEV_IDLE;
                    cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // busy flag, held sample and latched result
    always_ff @(posedge clock) begin
        if (sys_rst || arst) begin
            busy_q <= 1'b0;
            hold_q <= 16'h0000;
            result_q <= 16'h0000;
        end else begin
            if (conv_start) begin
                busy_q <= 1'b1;
                hold_q <= sample_value;
            end else if (conv_done) begin
                busy_q <= 1'b0;
                result_q <= hold_q;
            end
        end
    end

    // serial engine: master clock generation and slave shifting
    assign half_len = !rdc ? (4'h1 << div) : 4'h1;
    assign eff_clk = sclk_in ^ sinv;
    assign eff_rise = eff_clk && !clk_prev_q;
    assign mstart = ser && !ext && pend_q && out_en && !sact_q;
    assign sstart = ser && ext && out_en && !en_prev_q;

    always_ff @(posedge clock) begin
        if (sys_rst || arst) begin
            pend_q <= 1'b0;
            sact_q <= 1'b0;
            ph_q <= 1'b0;
            hc_q <= 4'h0;
            bit_q <= 5'h00;
            sh_q <= 16'h0000;
            rderr_q <= 1'b0;
        end else begin
            rderr_q <= 1'b0;
            // read mode high sends previous word at start, low at done
            if ((rdc && conv_start) || (!rdc && conv_done)) begin
                pend_q <= 1'b1;
            end else if (mstart) begin
                pend_q <= 1'b0;
            end
            if (ser && ext && sact_q && conv_done) begin
                sact_q <= 1'b0;
                rderr_q <= 1'b1;
            end else if (mstart || sstart) begin
                sh_q <= coded;
                bit_q <= 5'h00;
                sact_q <= 1'b1;
                ph_q <= 1'b0;
                hc_q <= half_len - 4'h1;
            end else if (ser && !ext && sact_q) begin
                if (hc_q == 4'h0) begin
                    hc_q <= half_len - 4'h1;
                    ph_q <= !ph_q;
                    if (ph_q) begin
                        sh_q <= {sh_q[14:0], 1'b0};
                        bit_q <= bit_q + 5'h01;
                        sact_q <= (bit_q != 5'h0f);
                    end
                end else begin
                    hc_q <= hc_q - 4'h1;
                end
            end else if (ser && ext && out_en && eff_rise) begin
                // clock counts only while chip select is low
                sh_q <= {sh_q[14:0], rdc};
                bit_q <= (bit_q == 5'h10) ? bit_q : bit_q + 5'h01;
                if (bit_q == 5'h0f) begin
                    sact_q <= 1'b0;
                end
            end
        end
    end

    // data bus and serial pin assignment
    always_comb begin
        d_o = 16'h0000;
        d_e = 16'h0000;
        if (!ser) begin
            d_o = bsw ? {coded[7:0], coded[15:8]} : coded;
            d_e = {16{out_en}};
        end else begin
            d_o[8] = sh_q[15];
            d_e[8] = out_en;
            d_o[9] = ph_q ^ sinv;
            d_e[9] = !ext;
            d_o[10] = (sact_q && !ext) ^ spol;
            d_e[10] = !ext;
            d_o[11] = rderr_q;
            d_e[11] = ext;
        end
    end

    // pin and status flip-flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            d_out_q <= 16'h0000;
            d_oe_q <= 16'h0000;
            low_power_active <= 1'b0;
            last_result <= 16'h0000;
        end else begin
            d_out_q <= d_o;
            d_oe_q <= d_e;
            low_power_active <= low_pwr_on || pd;
            last_result <= result_q;
        end
    end

    assign pins.d_dev_out = d_out_q;
    assign pins.d_dev_oe = d_oe_q;
    assign pins.busy = busy_q;
endmodule

/* rtl/sahp_host.sv */
`timescale 1ns/1ps
`include "sahp_defines.svh"
module sahp_host import sahp_pkg::*; #(
    parameter int FAST_GAP = `SAHP_FAST_GAP_CYC
) (
    input logic clock,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sahp_if.host pins
);
    logic [16:0] s;
    logic busy_s, serial_result_out_s, clk_s, rderr_s;
    logic [`SAHP_CTRL_W-1:0] ctrl_q;
    logic valid_q, rderr_q, conv_req_q, read_req_q;
    logic [15:0] result_q, sh_q, cnt_q, gap_q;
    logic [4:0] bit_q;
    sahp_host_state_t state_q;
    logic cnv_n_q, csrd_n_q, eff_q, prev_q, wr, done, keep;
    logic [15:0] d_out_q, d_oe_q;

    // device pins come back through two flip-flops
    sahp_sync2 #(.W(17), .RST_VAL(17'h00000)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({pins.busy, pins.d_wire}),
        .sync_out(s)
    );
    assign busy_s = s[16];
    assign serial_result_out_s = s[8];
    assign clk_s = s[9] ^ ctrl_q[`SAHP_CTRL_CLK_INV];
    assign rderr_s = s[11];
    assign wr = psel && penable && pready && pwrite;
    assign done = (state_q == H_PAR && cnt_q == 16'h0001) ||
                  (state_q == H_SER_M && clk_s && !prev_q &&
                   bit_q == 5'h0f) ||
                  (state_q == H_SER_S && eff_q && cnt_q == 16'h0001 &&
                   bit_q == 5'h10);
    // fast mode needs a minimum conversion rate
    assign keep = ctrl_q[`SAHP_CTRL_FAST] && !ctrl_q[`SAHP_CTRL_LOWPWR] &&
                  (gap_q == 16'(FAST_GAP));

    // apb slave: no wait states, errors on unmapped offsets
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrl_q <= `SAHP_CTRL_RESET;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `SAHP_REG_RESULT ||
                                            paddr[1:0] != 2'b00);
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `SAHP_REG_CTRL: prdata <= 32'(ctrl_q);
                    `SAHP_REG_STATUS: prdata <= {28'h0000000,
                        state_q != H_IDLE, rderr_q, valid_q, busy_s};
                    `SAHP_REG_RESULT: prdata <= {16'h0000, result_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (wr && paddr == `SAHP_REG_CTRL) begin
                ctrl_q <= pwdata[`SAHP_CTRL_W-1:0];
            end
        end
    end

    // requests, sticky status and the keep-alive gap counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conv_req_q <= 1'b0;
            read_req_q <= 1'b0;
            valid_q <= 1'b0;
            rderr_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            if (wr && paddr == `SAHP_REG_CMD &&
                pwdata[`SAHP_CMD_CONVERT]) begin
                conv_req_q <= 1'b1;
            end else if (keep) begin
                conv_req_q <= 1'b1;
            end else if (state_q == H_IDLE) begin
                conv_req_q <= 1'b0;
            end
            if (wr && paddr == `SAHP_REG_CMD && pwdata[`SAHP_CMD_READ]) begin
                read_req_q <= 1'b1;
            end else if (state_q == H_IDLE && !conv_req_q) begin
                read_req_q <= 1'b0;
            end
            // set wins over a write-one clear
            if (done) begin
                valid_q <= 1'b1;
            end else if (wr && paddr == `SAHP_REG_STATUS &&
                         pwdata[`SAHP_STAT_VALID]) begin
                valid_q <= 1'b0;
            end
            if (rderr_s && ctrl_q[`SAHP_CTRL_IFACE] &&
                ctrl_q[`SAHP_CTRL_CLK_SRC]) begin
                rderr_q <= 1'b1;
            end else if (wr && paddr == `SAHP_REG_STATUS &&
                         pwdata[`SAHP_STAT_RDERR]) begin
                rderr_q <= 1'b0;
            end
            gap_q <= (state_q == H_CNV || keep) ? 16'h0000 : gap_q + 16'h0001;
        end
    end

    // pin sequencer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 5'h00;
            sh_q <= 16'h0000;
            result_q <= 16'h0000;
            cnv_n_q <= 1'b1;
            csrd_n_q <= 1'b1;
            eff_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            prev_q <= clk_s;
            case (state_q)
                H_IDLE: begin
                    bit_q <= 5'h00;
                    eff_q <= 1'b0;
                    if (conv_req_q) begin
                        state_q <= H_CNV;
                        cnv_n_q <= 1'b0;
                        cnt_q <= 16'(`SAHP_CNV_PULSE_CYC);
                    end else if (read_req_q) begin
                        csrd_n_q <= 1'b0;
                        cnt_q <= !ctrl_q[`SAHP_CTRL_IFACE] ?
                                 16'(`SAHP_PAR_WAIT_CYC) :
                                 16'(`SAHP_SLAVE_HALF_CYC);
                        state_q <= !ctrl_q[`SAHP_CTRL_IFACE] ? H_PAR :
                                   (ctrl_q[`SAHP_CTRL_CLK_SRC] ? H_SER_S :
                                    H_SER_M);
                    end
                end
                H_CNV: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        cnv_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                H_PAR: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (done) begin
                        result_q <= ctrl_q[`SAHP_CTRL_BYTE_ORDER] ?
                                    {s[7:0], s[15:8]} : s[15:0];
                        csrd_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                H_SER_M: begin
                    // sample on the rising edge of the device's clock
                    if (clk_s && !prev_q) begin
                        sh_q <= {sh_q[14:0], serial_result_out_s};
                        bit_q <= bit_q + 5'h01;
                        if (done) begin
                            result_q <= {sh_q[14:0], serial_result_out_s};
                            csrd_n_q <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    end
                end
                H_SER_S: begin
                    // clock toggles only while chip select is low
                    cnt_q <= cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        cnt_q <= 16'(`SAHP_SLAVE_HALF_CYC);
                        if (!eff_q) begin
                            sh_q <= {sh_q[14:0], serial_result_out_s};
                            bit_q <= bit_q + 5'h01;
                            eff_q <= 1'b1;
                        end else if (done) begin
                            result_q <= sh_q;
                            eff_q <= 1'b0;
                            csrd_n_q <= 1'b1;
                            state_q <= H_IDLE;
                        end else begin
                            eff_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                    cnv_n_q <= 1'b1;
                    csrd_n_q <= 1'b1;
                end
            endcase
        end
    end

    // serial configuration and slave clock onto the shared lines
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            d_out_q <= 16'h0000;
            d_oe_q <= 16'h0000;
        end else begin
            d_out_q <= 16'h0000;
            d_oe_q <= 16'h0000;
            if (ctrl_q[`SAHP_CTRL_IFACE]) begin
                d_oe_q[7:2] <= 6'h3f;
                d_oe_q[9] <= ctrl_q[`SAHP_CTRL_CLK_SRC];
                d_out_q[3:2] <= ctrl_q[`SAHP_CTRL_DIV_HI:`SAHP_CTRL_DIV_LO];
                d_out_q[4] <= ctrl_q[`SAHP_CTRL_CLK_SRC];
                d_out_q[5] <= ctrl_q[`SAHP_CTRL_SYNC_POL];
                d_out_q[6] <= ctrl_q[`SAHP_CTRL_CLK_INV];
                d_out_q[7] <= ctrl_q[`SAHP_CTRL_READ_MODE] &&
                              !ctrl_q[`SAHP_CTRL_CLK_SRC];
                d_out_q[9] <= eff_q ^ ctrl_q[`SAHP_CTRL_CLK_INV];
            end
        end
    end

    assign pins.convert_start_n = cnv_n_q;
    assign pins.cs_n = csrd_n_q;
    assign pins.rd_n = csrd_n_q;
    assign pins.adc_reset = ctrl_q[`SAHP_CTRL_ADC_RST];
    assign pins.power_down_in = ctrl_q[`SAHP_CTRL_PWR_DOWN];
    assign pins.byte_order_sel = ctrl_q[`SAHP_CTRL_BYTE_ORDER];
    assign pins.output_coding_sel = ctrl_q[`SAHP_CTRL_CODING];
    assign pins.interface_sel = ctrl_q[`SAHP_CTRL_IFACE];
    assign pins.fast_mode = ctrl_q[`SAHP_CTRL_FAST];
    assign pins.low_power_mode = ctrl_q[`SAHP_CTRL_LOWPWR];
    assign pins.d_host_out = d_out_q;
    assign pins.d_host_oe = d_oe_q;
endmodule

/* rtl/sahp_if.sv */
`timescale 1ns/1ps
interface sahp_if;
    logic convert_start_n;
    logic cs_n;
    logic rd_n;
    logic adc_reset;
    logic power_down_in;
    logic byte_order_sel;
    logic output_coding_sel;
    logic interface_sel;
    logic fast_mode;
    logic low_power_mode;
    logic busy;
    logic [15:0] d_dev_out;
    logic [15:0] d_dev_oe;
    logic [15:0] d_host_out;
    logic [15:0] d_host_oe;
    logic [15:0] d_wire;

    // resolve each shared data line; an undriven line reads low
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_bit
            assign d_wire[i] = d_dev_oe[i] ? d_dev_out[i] :
                               (d_host_oe[i] & d_host_out[i]);
        end
    endgenerate

    modport device(
        input convert_start_n, cs_n, rd_n, adc_reset, power_down_in,
        input byte_order_sel, output_coding_sel, interface_sel,
        input fast_mode, low_power_mode, d_wire,
        output busy, d_dev_out, d_dev_oe
    );
    modport host(
        output convert_start_n, cs_n, rd_n, adc_reset, power_down_in,
        output byte_order_sel, output_coding_sel, interface_sel,
        output fast_mode, low_power_mode, d_host_out, d_host_oe,
        input busy, d_wire
    );
endinterface

/* rtl/sahp_pkg.sv */
package sahp_pkg;
    // converter sequencing states of the device end
    typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_ACQ} sahp_dev_state_t;
    // host sequencing states
    typedef enum logic [2:0] {
        H_IDLE, H_CNV, H_PAR, H_SER_M, H_SER_S
    } sahp_host_state_t;
endpackage

/* rtl/sahp_sync2.sv */
`timescale 1ns/1ps
module sahp_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input logic clock,
    input logic sys_rst,
    input logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
